// >>> bench/dimm_presence_timing_fields_tb.sv
// self-checking bench for the presence-detect timing and feature store
`timescale 1ns/1ns
`default_nettype none
module dimm_presence_timing_fields_tb;
    localparam logic [1:0] OK = spdt_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = spdt_pkg::RESP_SLVERR;
    logic mclk_in = 1'b0, rst_in = 1'b1, lane = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [9:0] addr = 10'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0, resv, clk_in, feat;
    logic awready, wready, bvalid, arready, rvalid, f100, f66, dec_resv;
    logic [1:0] bresp, rresp;
    logic [7:0] raw = 8'h00, tenths, sum;
    int n_fail = 0, n_tests = 0;
    always #4 mclk_in = ~mclk_in;
    // one address bus feeds both channels: awvalid and arvalid are never raised together
    spdt_store u_dut (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .s_axi_awaddr_in(addr),
        .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb),
        .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready),
        .s_axi_araddr_in(addr),
        .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready),
        .module_clock_in_zero_out(clk_in[3]),
        .module_clock_in_one_out(clk_in[2]),
        .module_clock_in_two_out(clk_in[1]),
        .module_clock_in_three_out(clk_in[0]),
        .temp_grade_a_out(feat[3]),
        .cas_latency_three_support_out(feat[2]),
        .cas_latency_two_support_out(feat[1]),
        .concurrent_autoprecharge_support_out(feat[0]),
        .host_freq_100_out(f100),
        .host_freq_66_out(f66),
        .reserved_encoding_out(resv)
    );
    spdt_host_decoder u_host (
        .raw_in(raw),
        .tenths_out(tenths),
        .reserved_out(dec_resv)
    );
    task automatic check(input logic [33:0] seen, input logic [33:0] want, input string what);
        n_tests++;
        if (seen !== want)
        begin
            n_fail++;
            $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // w high: write d[7:0] and expect response er; low: read, expect d and er
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        logic done = 1'b0;
        @(posedge mclk_in);
        addr <= a;
        wdata <= d;
        wstrb <= {3'h7, lane};
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        while (!done && n < 64)
        begin
            @(posedge mclk_in);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (arready)
                arvalid <= 1'b0;
            if (bvalid || rvalid)
            begin
                done = 1'b1;
                bready <= 1'b0;
                rready <= 1'b0;
                check(w ? {bresp, 32'h0} : {rresp, rdata}, {er, w ? 32'h0 : d}, "bus answer");
            end
        end
        check({33'h0, done}, 34'h1, "answer in time");
        if (!done)
            end_of_test();
    endtask : bus
    task automatic test_reset();
        bus(1'b0, 10'h0F8, 32'h10, OK);
        bus(1'b0, 10'h0FC, 32'h10, OK);
        bus(1'b0, 10'h20C, 32'h00, ERR);
        bus(1'b1, 10'h204, 32'h01, ERR);
        bus(1'b1, 10'h080, 32'h25, ERR);
        bus(1'b0, 10'h080, 32'h00, OK);
        check({32'h0, f100, f66}, 34'h2, "frequency flags");
        $display("test reset done");
    endtask : test_reset
    task automatic test_timing();
        logic [7:0] tv [4] = '{8'h25, 8'h85, 8'h7A, 8'hF9};
        logic [31:0] ed;
        logic [3:0] er;
        bus(1'b1, 10'h200, 32'h01, OK);
        for (int i = 0; i < 4; i++)
        begin
            raw = tv[i];
            bus(1'b1, 10'h080 + 10'(4 * i), {24'h0, tv[i]}, OK);
            ed[8 * i +: 8] = tenths;
            er[i] = dec_resv;
        end
        bus(1'b1, 10'h0F8, 32'h34, OK);
        bus(1'b0, 10'h208, ed, OK);
        check({30'h0, resv}, {30'h0, er}, "reserved tenths");
        bus(1'b0, 10'h204, {26'h0, 2'h3, er}, OK);
        sum = 8'h25 + 8'h85 + 8'h7A + 8'hF9 + 8'h34;
        bus(1'b0, 10'h0FC, {24'h0, sum}, OK);
        bus(1'b1, 10'h0FC, 32'h00, ERR);
        // lane 0 off: accepted but must leave the byte alone
        lane = 1'b0;
        bus(1'b1, 10'h080, 32'h11, OK);
        lane = 1'b1;
        bus(1'b0, 10'h080, 32'h25, OK);
        $display("test timing done");
    endtask : test_timing
    task automatic test_ident();
        bus(1'b1, 10'h200, 32'h03, OK);
        bus(1'b1, 10'h100, 32'hAB, ERR);
        bus(1'b1, 10'h1F4, 32'hAB, ERR);
        bus(1'b1, 10'h200, 32'h01, OK);
        bus(1'b1, 10'h1F4, 32'hAB, OK);
        bus(1'b0, 10'h1F4, 32'hAB, OK);
        bus(1'b0, 10'h0FC, {24'h0, sum}, OK);
        $display("test ident done");
    endtask : test_ident
    task automatic test_flags();
        logic [7:0] fv [5] = '{8'h00, 8'hA7, 8'h5C, 8'h02, 8'hFF};
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, 10'h1FC, {24'h0, fv[i]}, OK);
            repeat (2) @(posedge mclk_in);
            check({26'h0, clk_in, feat}, {26'h0, fv[i][7:2], &fv[i][2:1], fv[i][0]}, "flags");
        end
        bus(1'b1, 10'h1F8, 32'h66, OK);
        repeat (2) @(posedge mclk_in);
        check({32'h0, f100, f66}, 34'h1, "frequency flags");
        $display("test flags done");
    endtask : test_flags
    initial
    begin
        repeat (6) @(posedge mclk_in);
        rst_in <= 1'b0;
        test_reset();
        test_timing();
        test_ident();
        test_flags();
        end_of_test();
    end
endmodule : dimm_presence_timing_fields_tb
`default_nettype wire

// >>> bench/spdt_host_decoder.sv
// host-side reading of one signed setup or hold timing byte
`timescale 1ns/1ns
`default_nettype none
module spdt_host_decoder (
    input wire logic [7:0] raw_in,
    output logic [7:0] tenths_out,
    output logic reserved_out
);
    logic [7:0] mag;
    assign mag = {5'h00, raw_in[6:4]} * 8'h0A + {4'h0, raw_in[3:0]};
    assign reserved_out = raw_in[3:0] > 4'h9;
    assign tenths_out = reserved_out ? 8'h00 : (raw_in[7] ? 8'h00 - mag : mag);
endmodule : spdt_host_decoder
`default_nettype wire

// >>> design/spdt_dec_if.sv
// carrier between the store and one signed timing byte decoder
`timescale 1ns/1ns
`default_nettype none
interface spdt_dec_if;
    logic [7:0] raw;
    logic negative;
    logic [2:0] whole;
    logic [3:0] tenth;
    logic reserved_enc;
    logic [7:0] total;
    modport dec (input raw, output negative, whole, tenth, reserved_enc, total);
    modport user (output raw, input negative, whole, tenth, reserved_enc, total);
endinterface : spdt_dec_if
`default_nettype wire

// >>> design/spdt_pkg.sv
// constants for the presence-detect timing and feature store
package spdt_pkg;
    // ------------------------------------------------------------
    // store geometry and bus map
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int STORE_DEPTH = 128;
    localparam int TIMING_BYTES = 4;
    localparam logic [9:0] ADDR_CTRL = 10'h200;
    localparam logic [9:0] ADDR_STATUS = 10'h204;
    localparam logic [9:0] ADDR_DECODE = 10'h208;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // byte indices inside the store (byte address is four times)
    // ------------------------------------------------------------
    localparam logic [6:0] IDX_CA_SETUP = 7'h20;
    localparam logic [6:0] IDX_CA_HOLD = 7'h21;
    localparam logic [6:0] IDX_DATA_SETUP = 7'h22;
    localparam logic [6:0] IDX_DATA_HOLD = 7'h23;
    localparam logic [6:0] IDX_REVISION = 7'h3E;
    localparam logic [6:0] IDX_CHECKSUM = 7'h3F;
    localparam logic [6:0] IDX_ID_FIRST = 7'h40;
    localparam logic [6:0] IDX_ID_LAST = 7'h47;
    localparam logic [6:0] IDX_LOCATION = 7'h48;
    localparam logic [6:0] IDX_PART_FIRST = 7'h49;
    localparam logic [6:0] IDX_PART_LAST = 7'h5A;
    localparam logic [6:0] IDX_REVCODE_FIRST = 7'h5B;
    localparam logic [6:0] IDX_REVCODE_LAST = 7'h5C;
    localparam logic [6:0] IDX_SERIAL_FIRST = 7'h5F;
    localparam logic [6:0] IDX_SERIAL_LAST = 7'h62;
    localparam logic [6:0] IDX_VENDOR_FIRST = 7'h63;
    localparam logic [6:0] IDX_VENDOR_LAST = 7'h7D;
    localparam logic [6:0] IDX_HOST_FREQ = 7'h7E;
    localparam logic [6:0] IDX_FLAGS = 7'h7F;
    // ------------------------------------------------------------
    // field layouts and codes
    // ------------------------------------------------------------
    localparam int SIGN_BIT = 7;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [7:0] WHOLE_SCALE = 8'h0A;
    localparam logic [7:0] FREQ_100 = 8'h64;
    localparam logic [7:0] FREQ_66 = 8'h66;
    localparam int FLAG_TEMP_BIT = 3;
    localparam int FLAG_AP_BIT = 0;
    localparam logic [1:0] CAS3_ONLY = 2'h2;
    localparam logic [1:0] CAS2_ALSO = 2'h3;
    localparam int CTRL_UNLOCK_BIT = 0;
    localparam int CTRL_IDPROT_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;
    localparam logic [7:0] TIMING_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
endpackage : spdt_pkg

// >>> design/spdt_store.sv
// presence-detect store with timing decode, checksum and axi4-lite access
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module spdt_store #(
    // arbitrary revision value, load the real one over the bus
    parameter logic [7:0] REVISION_CODE = 8'h10,
    parameter logic [7:0] HOST_FREQ_RESET = 8'h64
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [9:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [9:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic module_clock_in_zero_out,
    output logic module_clock_in_one_out,
    output logic module_clock_in_two_out,
    output logic module_clock_in_three_out,
    output logic temp_grade_a_out,
    output logic cas_latency_three_support_out,
    output logic cas_latency_two_support_out,
    output logic concurrent_autoprecharge_support_out,
    output logic host_freq_100_out,
    output logic host_freq_66_out,
    output logic [3:0] reserved_encoding_out
);
    // ------------------------------------------------------------
    // storage and control state
    // ------------------------------------------------------------
    logic [7:0] store_r [spdt_pkg::STORE_DEPTH];
    logic [1:0] ctrl_r;
    logic [9:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_lane0_r;
    logic [7:0] dec_total [spdt_pkg::TIMING_BYTES];
    logic [3:0] dec_rsvd;
    logic wr_fire;
    logic [6:0] wr_idx;
    logic wr_store_ok;
    logic wr_ctrl;
    logic id_range;
    logic rev_bcd_ok;
    logic freq_known;
    logic [31:0] rd_word;
    logic rd_err;

    // ------------------------------------------------------------
    // timing byte decoders
    // ------------------------------------------------------------
    // four consecutive timing bytes
    for (genvar g = 0; g < spdt_pkg::TIMING_BYTES; g++)
    begin : g_dec
        localparam logic [6:0] IDX = 7'(spdt_pkg::IDX_CA_SETUP + g);
        spdt_dec_if dbus ();
        assign dbus.raw = store_r[IDX];
        spdt_time_dec u_dec (
            .bus(dbus)
        );
        assign dec_total[g] = dbus.total;
        assign dec_rsvd[g] = dbus.reserved_enc;
    end

    // ------------------------------------------------------------
    // write path decode
    // ------------------------------------------------------------
    assign wr_fire = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;
    assign wr_idx = aw_addr_r[8:2];
    // identity regions guarded separately from the rest
    assign id_range = wr_idx >= spdt_pkg::IDX_ID_FIRST && wr_idx <= spdt_pkg::IDX_VENDOR_LAST;
    // checksum byte is owned by hardware, never written directly
    assign wr_store_ok = !aw_addr_r[9] && ctrl_r[spdt_pkg::CTRL_UNLOCK_BIT]
        && wr_idx != spdt_pkg::IDX_CHECKSUM && !(ctrl_r[spdt_pkg::CTRL_IDPROT_BIT] && id_range);
    assign wr_ctrl = aw_addr_r == spdt_pkg::ADDR_CTRL;

    // ------------------------------------------------------------
    // write address and data channels
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            s_axi_awready_out <= 1'b1;
            aw_addr_r <= 10'h000;
        end
        else if (s_axi_awvalid_in && s_axi_awready_out)
        begin
            s_axi_awready_out <= 1'b0;
            aw_addr_r <= s_axi_awaddr_in;
        end
        else if (wr_fire)
        begin
            s_axi_awready_out <= 1'b1;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            s_axi_wready_out <= 1'b1;
            w_data_r <= 8'h00;
            w_lane0_r <= 1'b0;
        end
        else if (s_axi_wvalid_in && s_axi_wready_out)
        begin
            s_axi_wready_out <= 1'b0;
            w_data_r <= s_axi_wdata_in[7:0];
            w_lane0_r <= s_axi_wstrb_in[0];
        end
        else if (wr_fire)
        begin
            s_axi_wready_out <= 1'b1;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= spdt_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (wr_store_ok || wr_ctrl) ? spdt_pkg::RESP_OKAY : spdt_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready_in)
        begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            ctrl_r <= spdt_pkg::CTRL_RESET;
        end
        else if (wr_fire && wr_ctrl && w_lane0_r)
        begin
            ctrl_r <= w_data_r[1:0];
        end
    end

    // ------------------------------------------------------------
    // byte store with running checksum
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            for (int k = 0; k < spdt_pkg::STORE_DEPTH; k++)
            begin
                store_r[k] <= spdt_pkg::TIMING_RESET;
            end
            store_r[spdt_pkg::IDX_REVISION] <= REVISION_CODE;
            // only the revision byte is nonzero below the checksum
            store_r[spdt_pkg::IDX_CHECKSUM] <= REVISION_CODE;
            store_r[spdt_pkg::IDX_HOST_FREQ] <= HOST_FREQ_RESET;
            store_r[spdt_pkg::IDX_FLAGS] <= spdt_pkg::FLAGS_RESET;
        end
        else if (wr_fire && wr_store_ok && w_lane0_r)
        begin
            store_r[wr_idx] <= w_data_r;
            // swap old byte for new in the sum
            if (wr_idx < spdt_pkg::IDX_CHECKSUM)
            begin
                store_r[spdt_pkg::IDX_CHECKSUM] <= store_r[spdt_pkg::IDX_CHECKSUM] - store_r[wr_idx] + w_data_r;
            end
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // both revision nibbles must be decimal digits
    assign rev_bcd_ok = store_r[spdt_pkg::IDX_REVISION][7:4] <= spdt_pkg::DIGIT_MAX
        && store_r[spdt_pkg::IDX_REVISION][3:0] <= spdt_pkg::DIGIT_MAX;
    assign freq_known = store_r[spdt_pkg::IDX_HOST_FREQ] == spdt_pkg::FREQ_100
        || store_r[spdt_pkg::IDX_HOST_FREQ] == spdt_pkg::FREQ_66;

    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        if (!s_axi_araddr_in[9])
        begin
            rd_word[7:0] = store_r[s_axi_araddr_in[8:2]];
        end
        else if (s_axi_araddr_in == spdt_pkg::ADDR_CTRL)
        begin
            rd_word[1:0] = ctrl_r;
        end
        else if (s_axi_araddr_in == spdt_pkg::ADDR_STATUS)
        begin
            rd_word[5:0] = {freq_known, rev_bcd_ok, dec_rsvd};
        end
        else if (s_axi_araddr_in == spdt_pkg::ADDR_DECODE)
        begin
            rd_word = {dec_total[3], dec_total[2], dec_total[1], dec_total[0]};
        end
        else
        begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= spdt_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_word;
            s_axi_rresp_out <= rd_err ? spdt_pkg::RESP_SLVERR : spdt_pkg::RESP_OKAY;
        end
        else if (s_axi_rvalid_out && s_axi_rready_in)
        begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // feature flag and frequency outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            module_clock_in_zero_out <= 1'b0;
            module_clock_in_one_out <= 1'b0;
            module_clock_in_two_out <= 1'b0;
            module_clock_in_three_out <= 1'b0;
            temp_grade_a_out <= 1'b0;
            cas_latency_three_support_out <= 1'b0;
            cas_latency_two_support_out <= 1'b0;
            concurrent_autoprecharge_support_out <= 1'b0;
            host_freq_100_out <= 1'b0;
            host_freq_66_out <= 1'b0;
            reserved_encoding_out <= 4'h0;
        end
        else
        begin
            // set bit means the clock input is wired
            module_clock_in_zero_out <= store_r[spdt_pkg::IDX_FLAGS][7];
            module_clock_in_one_out <= store_r[spdt_pkg::IDX_FLAGS][6];
            module_clock_in_two_out <= store_r[spdt_pkg::IDX_FLAGS][5];
            module_clock_in_three_out <= store_r[spdt_pkg::IDX_FLAGS][4];
            temp_grade_a_out <= store_r[spdt_pkg::IDX_FLAGS][spdt_pkg::FLAG_TEMP_BIT];
            cas_latency_three_support_out <= store_r[spdt_pkg::IDX_FLAGS][2:1] == spdt_pkg::CAS3_ONLY
                || store_r[spdt_pkg::IDX_FLAGS][2:1] == spdt_pkg::CAS2_ALSO;
            cas_latency_two_support_out <= store_r[spdt_pkg::IDX_FLAGS][2:1] == spdt_pkg::CAS2_ALSO;
            concurrent_autoprecharge_support_out <= store_r[spdt_pkg::IDX_FLAGS][spdt_pkg::FLAG_AP_BIT];
            host_freq_100_out <= store_r[spdt_pkg::IDX_HOST_FREQ] == spdt_pkg::FREQ_100;
            host_freq_66_out <= store_r[spdt_pkg::IDX_HOST_FREQ] == spdt_pkg::FREQ_66;
            // flag tenths codes the reader must reject
            reserved_encoding_out <= dec_rsvd;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [7:0] full_sum;
    logic [7:0] mag0;

    always_comb
    begin
        full_sum = 8'h00;
        for (int k = 0; k < int'(spdt_pkg::IDX_CHECKSUM); k++)
        begin
            full_sum = full_sum + store_r[k];
        end
    end
    assign mag0 = dec_total[0][7] ? 8'(-dec_total[0]) : dec_total[0];

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    sequence rd_at(logic [9:0] addr);
        s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == addr;
    endsequence

    sign_decode_a: assert property (
        !dec_rsvd[0] |-> dec_total[0][7] == (store_r[spdt_pkg::IDX_CA_SETUP][7] && dec_total[0] != 8'h00))
        else $error("timing sign does not follow bit 7");
    whole_ns_a: assert property (
        !dec_rsvd[0] |-> mag0 / spdt_pkg::WHOLE_SCALE == {5'h00, store_r[spdt_pkg::IDX_CA_SETUP][6:4]})
        else $error("whole nanoseconds wrong");
    tenth_add_a: assert property (
        !dec_rsvd[0] |-> mag0 % spdt_pkg::WHOLE_SCALE == {4'h0, store_r[spdt_pkg::IDX_CA_SETUP][3:0]})
        else $error("tenths not added");
    setup_read_a: assert property (
        rd_at(10'h080) |=> s_axi_rvalid_out && s_axi_rdata_out == {24'h000000, $past(store_r[32])})
        else $error("setup byte read wrong");
    hold_decode_a: assert property (
        rd_at(spdt_pkg::ADDR_DECODE) |=> s_axi_rdata_out[31:24] == $past(dec_total[3]))
        else $error("data hold decode misplaced");
    rev_bcd_a: assert property (
        rd_at(spdt_pkg::ADDR_STATUS) ##1 s_axi_rvalid_out |-> s_axi_rdata_out[4] == $past(rev_bcd_ok))
        else $error("revision bcd flag wrong");
    sum_match_a: assert property (
        store_r[spdt_pkg::IDX_CHECKSUM] == full_sum)
        else $error("checksum byte differs from sum");
    id_guard_a: assert property (
        wr_fire && ctrl_r[spdt_pkg::CTRL_IDPROT_BIT] && !aw_addr_r[9] && id_range
        |=> s_axi_bresp_out == spdt_pkg::RESP_SLVERR && store_r[$past(wr_idx)] == $past(store_r[wr_idx]))
        else $error("protected identity byte written");
    freq_code_a: assert property (
        !$past(rst_in) |-> host_freq_100_out == $past(store_r[spdt_pkg::IDX_HOST_FREQ] == spdt_pkg::FREQ_100))
        else $error("frequency flag wrong");
    clk_conn_a: assert property (
        ##1 {module_clock_in_zero_out, module_clock_in_one_out, module_clock_in_two_out,
        module_clock_in_three_out} == $past(store_r[spdt_pkg::IDX_FLAGS][7:4]))
        else $error("clock connection flags wrong");
    temp_grade_a: assert property (
        !$past(rst_in) |-> temp_grade_a_out == $past(store_r[spdt_pkg::IDX_FLAGS][3]))
        else $error("temperature grade wrong");
    cas_support_a: assert property (
        cas_latency_two_support_out |-> cas_latency_three_support_out
        && $past(store_r[spdt_pkg::IDX_FLAGS][2:1]) == 2'h3)
        else $error("cas latency decode wrong");
    autoprecharge_a: assert property (
        $rose(store_r[spdt_pkg::IDX_FLAGS][0]) |=> concurrent_autoprecharge_support_out)
        else $error("autoprecharge flag late");
endmodule : spdt_store
`default_nettype wire

// >>> design/spdt_time_dec.sv
// decoder of one signed setup or hold timing byte
`timescale 1ns/1ns
`default_nettype none
module spdt_time_dec (
    spdt_dec_if.dec bus
);
    logic [7:0] mag;

    always_comb
    begin
        bus.negative = bus.raw[spdt_pkg::SIGN_BIT];
        bus.whole = bus.raw[6:4];
        bus.tenth = bus.raw[3:0];
        bus.reserved_enc = bus.raw[3:0] > spdt_pkg::DIGIT_MAX;
        mag = 8'({5'h00, bus.raw[6:4]} * spdt_pkg::WHOLE_SCALE) + {4'h0, bus.raw[3:0]};
        // reserved tenths give no time at all rather than a bogus one
        if (bus.reserved_enc)
        begin
            bus.total = 8'h00;
        end
        else if (bus.negative)
        begin
            bus.total = 8'(-mag);
        end
        else
        begin
            bus.total = mag;
        end
    end
endmodule : spdt_time_dec
`default_nettype wire
